// ===== mwsc_pkg.sv
// Contract
// RL1 - the high-page extension register holds bits 22:21 for windows 4 to 7 of region a, window 7 in the top pair.
// RL2 - software sets the region-select bit to one before writing the high-page extension register.
// RL3 - each bit of the low shadow enable maps one 16 Kbyte block, bit 0 at 0c0000h up to bit 7 at 0dc000h.
// RL4 - each bit of the high shadow enable maps one 16 Kbyte block, bit 0 at 0e0000h up to bit 7 ending at 0fffffh.
// RL5 - every shadow enable bit leaves reset cleared so nothing is shadowed until software sets it.
// RL6 - software keeps the reserved index between the shadow enables and misc control two at zero.
// RL7 - idle-clock select at zero keeps idle cycles on the fast clock, at one moves them to the 9.2 MHz clock.
// RL8 - software leaves the idle-clock select at zero when the processor runs at 33 MHz or 25 MHz.
// RL9 - during smi accesses a20 passes through when the pass bit is one and is forced low when it is zero.
// RL10 - the bit-23 extension register holds bit 23 for all eight windows, bit n for window n.
// RL11 - bits 3:0 of the bit-23 register exist once per region and the region-select bit picks the copy accessed.
// RL12 - software picks the target region with the region-select bit before programming the bit-23 register.
// RL13 - each window page value supplies translated bits 20:14 and is joined with the extension bits held here.
// RL14 - a separate low-page extension register supplies bits 22:21 for windows 0 to 3, shared by both regions.
// RL15 - an access inside an enabled window forms its address from extension 23:21, page 20:14 and cpu 13:0.
// RL16 - software writes zero to bit 7 and one to bit 4 of misc control two and treats 6, 5, 3 and 1 as reserved.
package mwsc_pkg;
   // -----------------------------------------------------------------
   // register indexes
   // -----------------------------------------------------------------
   localparam logic [7:0] MWSC_IDX_HIGH_PAGE_EXT = 8'h67;
   localparam logic [7:0] MWSC_IDX_SHADOW_LOW = 8'h68;
   localparam logic [7:0] MWSC_IDX_SHADOW_HIGH = 8'h69;
   localparam logic [7:0] MWSC_IDX_RESERVED = 8'h6a;
   localparam logic [7:0] MWSC_IDX_MISC_TWO = 8'h6b;
   localparam logic [7:0] MWSC_IDX_BIT23_EXT = 8'h6c;
   localparam logic [7:0] MWSC_IDX_LOW_PAGE_EXT = 8'h6e;

   // -----------------------------------------------------------------
   // reset values and field positions
   // -----------------------------------------------------------------
   localparam logic [7:0] MWSC_RST_BYTE = 8'h00;
   localparam logic [3:0] MWSC_RST_NIBBLE = 4'h0;
   localparam int MWSC_MISC_A20_BIT = 0;
   localparam int MWSC_MISC_IDLE_BIT = 2;
   localparam int MWSC_MISC_RSVD1_BIT = 4;
   localparam int MWSC_MISC_RSVD0_BIT = 7;

   // -----------------------------------------------------------------
   // address layout
   // -----------------------------------------------------------------
   localparam int MWSC_ADDR_W = 24;
   localparam int MWSC_PAGE_W = 7;
   localparam int MWSC_EXT_W = 3;
   localparam int MWSC_OFS_W = 14;
   localparam int MWSC_WIN_A = 8;
   localparam int MWSC_WIN_B = 4;
   localparam int MWSC_SHARED_WIN = 4;
   localparam logic [5:0] MWSC_SHADOW_TOP = 6'h03;
   localparam int MWSC_SHADOW_BLOCKS = 16;
endpackage

// ===== mwsc_rst_sync.sv
`timescale 1ns/10ps
module mwsc_rst_sync import mwsc_pkg::*; (
   input wire logic clk_sys,
   input wire logic rst_n,
   output logic rst_sync_n
);
   logic stage_n;

   // -----------------------------------------------------------------
   // release through two flops, assert at once
   // -----------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         stage_n <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         stage_n <= 1'b1;
         rst_sync_n <= stage_n;
      end
   end
endmodule

// ===== mwsc_win_xlate.sv
`timescale 1ns/10ps
module mwsc_win_xlate import mwsc_pkg::*; #(
   parameter int NWIN = 8,
   parameter int IW = 3
) (
   input wire logic clk_sys,
   input wire logic rst_sync_n,
   input wire logic win_hit,
   input wire logic [IW-1:0] win_index,
   input wire logic [NWIN*MWSC_PAGE_W-1:0] page_flat,
   input wire logic [NWIN*MWSC_EXT_W-1:0] ext_flat,
   input wire logic [MWSC_OFS_W-1:0] cpu_offset,
   output logic [MWSC_ADDR_W-1:0] phys_addr,
   output logic phys_valid
);
   // -----------------------------------------------------------------
   // elaboration check
   // -----------------------------------------------------------------
   if (NWIN < 1 || IW != $clog2(NWIN) || (1 << IW) != NWIN) begin : g_bad
      $error("window count must be a power of two matching the index width");
   end

   logic [MWSC_PAGE_W-1:0] sel_page;
   logic [MWSC_EXT_W-1:0] sel_ext;

   // pick the hit window's page and extension bits
   always_comb begin
      sel_page = page_flat[MWSC_PAGE_W*win_index +: MWSC_PAGE_W];
      sel_ext = ext_flat[MWSC_EXT_W*win_index +: MWSC_EXT_W];
   end

   // registered so the address leaves on a flop edge
   always_ff @(posedge clk_sys or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         phys_addr <= '0;
         phys_valid <= 1'b0;
      end else begin
         phys_valid <= win_hit;
         if (win_hit) begin
            phys_addr <= {sel_ext, sel_page, cpu_offset}; // RL15
         end
      end
   end
endmodule

// ===== mwsc_config.sv
`timescale 1ns/10ps
module mwsc_config import mwsc_pkg::*; (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic region_a_select,
   input wire logic [MWSC_ADDR_W-1:0] cpu_addr,
   input wire logic smi_active,
   input wire logic win_a_hit,
   input wire logic [2:0] win_a_index,
   input wire logic [MWSC_WIN_A*MWSC_PAGE_W-1:0] window_region_a_page,
   input wire logic win_b_hit,
   input wire logic [1:0] win_b_index,
   input wire logic [MWSC_WIN_B*MWSC_PAGE_W-1:0] window_region_b_page,
   output logic [MWSC_ADDR_W-1:0] window_region_a_addr,
   output logic window_region_a_valid,
   output logic [MWSC_ADDR_W-1:0] window_region_b_addr,
   output logic window_region_b_valid,
   output logic [2*8-1:0] shadow_en,
   output logic shadow_hit,
   output logic idle_clk_low_sel,
   output logic a20_out
);
   logic rst_sync_n;
   logic [7:0] high_page_addr_ext;
   logic [7:0] shadow_enable_low;
   logic [7:0] shadow_enable_high;
   logic [7:0] low_page_ext;
   logic [3:0] bit23_upper;
   logic [3:0] bit23_lower_a;
   logic [3:0] bit23_lower_b;
   logic misc_rsvd_one;
   logic smi_a20_pass;
   logic wr_high_ext;
   logic wr_bit23;
   logic [7:0] next_rdata;
   logic [7:0] addr_bit23_ext_view;
   logic [7:0] misc_control_two_view;
   logic [MWSC_WIN_A*MWSC_EXT_W-1:0] ext_a_flat;
   logic [MWSC_WIN_B*MWSC_EXT_W-1:0] ext_b_flat;

   // -----------------------------------------------------------------
   // reset release
   // -----------------------------------------------------------------
   mwsc_rst_sync u_rst_sync (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .rst_sync_n(rst_sync_n)
   );

   // -----------------------------------------------------------------
   // write decode
   // -----------------------------------------------------------------
   // high-page writes land only with region a selected, a stray write with region b up is dropped
   assign wr_high_ext = reg_wr && reg_addr == MWSC_IDX_HIGH_PAGE_EXT && region_a_select; // RL2
   assign wr_bit23 = reg_wr && reg_addr == MWSC_IDX_BIT23_EXT;

   // high-page extension, region a windows 4 to 7
   always_ff @(posedge clk_sys or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         high_page_addr_ext <= MWSC_RST_BYTE;
      end else if (wr_high_ext) begin
         high_page_addr_ext <= reg_wdata; // RL1
      end
   end

   // shadow enables, both cleared by reset
   always_ff @(posedge clk_sys or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         shadow_enable_low <= MWSC_RST_BYTE; // RL5
         shadow_enable_high <= MWSC_RST_BYTE; // RL5
      end else if (reg_wr) begin
         if (reg_addr == MWSC_IDX_SHADOW_LOW) begin
            shadow_enable_low <= reg_wdata; // RL3
         end
         if (reg_addr == MWSC_IDX_SHADOW_HIGH) begin
            shadow_enable_high <= reg_wdata; // RL4
         end
      end
   end

   // misc control two; bit 7 and the read-only bits keep no state
   always_ff @(posedge clk_sys or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         misc_rsvd_one <= 1'b0;
         idle_clk_low_sel <= 1'b0;
         smi_a20_pass <= 1'b0;
      end else if (reg_wr && reg_addr == MWSC_IDX_MISC_TWO) begin
         misc_rsvd_one <= reg_wdata[MWSC_MISC_RSVD1_BIT];
         // no speed check here: software must keep it low at 33 and 25 MHz
         idle_clk_low_sel <= reg_wdata[MWSC_MISC_IDLE_BIT]; // RL7
         smi_a20_pass <= reg_wdata[MWSC_MISC_A20_BIT]; // RL9
      end
   end

   // bit-23 extension; lower nibble has one copy per region
   always_ff @(posedge clk_sys or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         bit23_upper <= MWSC_RST_NIBBLE;
         bit23_lower_a <= MWSC_RST_NIBBLE;
         bit23_lower_b <= MWSC_RST_NIBBLE;
      end else if (wr_bit23) begin
         if (region_a_select) begin
            bit23_upper <= reg_wdata[7:4]; // RL10
            bit23_lower_a <= reg_wdata[3:0]; // RL11
         end else begin
            // windows 4 to 7 exist only in region a, so their bits stay put
            bit23_lower_b <= reg_wdata[3:0]; // RL11
         end
      end
   end

   // low-page extension, one copy shared by both regions
   always_ff @(posedge clk_sys or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         low_page_ext <= MWSC_RST_BYTE;
      end else if (reg_wr && reg_addr == MWSC_IDX_LOW_PAGE_EXT) begin
         low_page_ext <= reg_wdata; // RL14
      end
   end

   // -----------------------------------------------------------------
   // read path
   // -----------------------------------------------------------------
   // bit-23 view follows the selected region; region b shows zero above
   assign addr_bit23_ext_view = region_a_select ? {bit23_upper, bit23_lower_a} : {4'h0, bit23_lower_b}; // RL11
   assign misc_control_two_view = {3'h0, misc_rsvd_one, 1'b0, idle_clk_low_sel, 1'b0, smi_a20_pass};

   // unmapped and reserved indexes read zero
   always_comb begin
      next_rdata = 8'h00;
      case (reg_addr)
         MWSC_IDX_HIGH_PAGE_EXT: begin
            next_rdata = high_page_addr_ext;
         end
         MWSC_IDX_SHADOW_LOW: begin
            next_rdata = shadow_enable_low;
         end
         MWSC_IDX_SHADOW_HIGH: begin
            next_rdata = shadow_enable_high;
         end
         MWSC_IDX_MISC_TWO: begin
            next_rdata = misc_control_two_view;
         end
         MWSC_IDX_BIT23_EXT: begin
            next_rdata = addr_bit23_ext_view;
         end
         MWSC_IDX_LOW_PAGE_EXT: begin
            next_rdata = low_page_ext;
         end
         default: begin
            next_rdata = 8'h00; // RL6
         end
      endcase
   end

   // read data stands for exactly the cycle after the strobe
   always_ff @(posedge clk_sys or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         reg_rdata <= next_rdata;
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   // -----------------------------------------------------------------
   // extension bits per window
   // -----------------------------------------------------------------
   for (genvar w = 0; w < MWSC_WIN_A; w++) begin : g_ext_a
      if (w < MWSC_SHARED_WIN) begin : g_low
         assign ext_a_flat[w*MWSC_EXT_W +: MWSC_EXT_W] = {bit23_lower_a[w], low_page_ext[2*w+1], low_page_ext[2*w]};
      end else begin : g_high
         // window 7 sits in the top pair of the high-page byte
         assign ext_a_flat[w*MWSC_EXT_W +: MWSC_EXT_W] = {bit23_upper[w-4], high_page_addr_ext[2*(w-4)+1],
            high_page_addr_ext[2*(w-4)]}; // RL1
      end
   end

   for (genvar w = 0; w < MWSC_WIN_B; w++) begin : g_ext_b
      assign ext_b_flat[w*MWSC_EXT_W +: MWSC_EXT_W] = {bit23_lower_b[w], low_page_ext[2*w+1], low_page_ext[2*w]};
   end

   // -----------------------------------------------------------------
   // window translation
   // -----------------------------------------------------------------
   // page values supply bits 20:14, joined with the extension bits
   mwsc_win_xlate #(
      .NWIN(MWSC_WIN_A),
      .IW(3)
   ) u_xlate_a (
      .clk_sys(clk_sys),
      .rst_sync_n(rst_sync_n),
      .win_hit(win_a_hit),
      .win_index(win_a_index),
      .page_flat(window_region_a_page), // RL13
      .ext_flat(ext_a_flat),
      .cpu_offset(cpu_addr[MWSC_OFS_W-1:0]),
      .phys_addr(window_region_a_addr),
      .phys_valid(window_region_a_valid)
   );

   mwsc_win_xlate #(
      .NWIN(MWSC_WIN_B),
      .IW(2)
   ) u_xlate_b (
      .clk_sys(clk_sys),
      .rst_sync_n(rst_sync_n),
      .win_hit(win_b_hit),
      .win_index(win_b_index),
      .page_flat(window_region_b_page), // RL13
      .ext_flat(ext_b_flat),
      .cpu_offset(cpu_addr[MWSC_OFS_W-1:0]),
      .phys_addr(window_region_b_addr),
      .phys_valid(window_region_b_valid)
   );

   // -----------------------------------------------------------------
   // shadow map and a20 gate
   // -----------------------------------------------------------------
   assign shadow_en = {shadow_enable_high, shadow_enable_low};

   // sixteen 16 Kbyte blocks from 0c0000h, index from cpu bits 17:14
   always_ff @(posedge clk_sys or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         shadow_hit <= 1'b0;
      end else begin
         shadow_hit <= cpu_addr[23:18] == MWSC_SHADOW_TOP && shadow_en[cpu_addr[17:14]]; // RL3 RL4
      end
   end

   // a20 gated only during smi; registered for a clean output
   always_ff @(posedge clk_sys or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         a20_out <= 1'b0;
      end else if (smi_active) begin
         a20_out <= cpu_addr[20] & smi_a20_pass; // RL9
      end else begin
         a20_out <= cpu_addr[20];
      end
   end

   // -----------------------------------------------------------------
   // assertions
   // -----------------------------------------------------------------
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_sync_n);

   a_high_ext_store: assert property (reg_wr && reg_addr == MWSC_IDX_HIGH_PAGE_EXT && region_a_select
      |=> high_page_addr_ext == $past(reg_wdata)) else $error("high-page write lost"); // RL1
   a_high_ext_guard: assert property (reg_wr && reg_addr == MWSC_IDX_HIGH_PAGE_EXT && !region_a_select
      |=> $stable(high_page_addr_ext)) else $error("high-page written with region b up"); // RL2
   a_shadow_low_map: assert property (cpu_addr[23:14] == 10'h037 |=> shadow_hit == $past(shadow_en[7], 1))
      else $error("low shadow map wrong"); // RL3
   a_shadow_high_map: assert property (cpu_addr[23:14] == 10'h03f |=> shadow_hit == $past(shadow_en[15]))
      else $error("top shadow block wrong"); // RL4
   a_shadow_reset_clear: assert property (!$past(rst_sync_n) |-> shadow_en == 16'h0000 && !shadow_hit)
      else $error("shadow set after reset"); // RL5
   a_rsvd_read_zero: assert property (reg_rd && reg_addr == MWSC_IDX_RESERVED |=> reg_rdata == 8'h00)
      else $error("reserved index not zero"); // RL6
   a_idle_select: assert property (reg_wr && reg_addr == MWSC_IDX_MISC_TWO
      |=> idle_clk_low_sel == $past(reg_wdata[2]) ##1 ($stable(idle_clk_low_sel) || $past(reg_wr)))
      else $error("idle select wrong"); // RL7
   a_a20_forced_low: assert property (smi_active && !smi_a20_pass |=> !a20_out)
      else $error("a20 not forced low"); // RL9
   a_a20_passes: assert property (smi_active && smi_a20_pass |=> a20_out == $past(cpu_addr[20]))
      else $error("a20 not passed"); // RL9
   a_bit23_region_b: assert property (wr_bit23 && !region_a_select
      |=> bit23_lower_b == $past(reg_wdata[3:0]) && $stable(bit23_upper) && $stable(bit23_lower_a))
      else $error("region b bit-23 copy wrong"); // RL11
   a_bit23_all_win: assert property (wr_bit23 && region_a_select ##1 reg_rd && reg_addr == MWSC_IDX_BIT23_EXT
      && region_a_select && !reg_wr |=> reg_rdata == $past(reg_wdata, 2)) else $error("bit-23 readback"); // RL10
   a_xlate_a_addr: assert property (win_a_hit |=> window_region_a_valid
      && window_region_a_addr[13:0] == $past(cpu_addr[13:0])
      && window_region_a_addr[20:14] == $past(window_region_a_page[7*win_a_index +: 7]))
      else $error("region a address wrong"); // RL15
   a_xlate_b_ext: assert property (win_b_hit |=> window_region_b_valid
      && window_region_b_addr[23] == $past(bit23_lower_b[win_b_index])
      && window_region_b_addr[22:21] == $past(low_page_ext[2*win_b_index +: 2]))
      else $error("region b extension wrong"); // RL14

   c_shadow_hit: cover property (reg_wr && reg_addr == MWSC_IDX_SHADOW_HIGH ##[1:20] shadow_hit);
   c_smi_gate: cover property (smi_active && !smi_a20_pass && cpu_addr[20] ##1 !a20_out);
   c_win_a: cover property (win_a_hit && win_a_index == 3'h7);
   c_win_b: cover property (win_b_hit && !region_a_select);
endmodule

// ===== tb_mem_window_shadow_config.sv
`timescale 1ns/10ps
module tb_mem_window_shadow_config import mwsc_pkg::*;;
   // -----------------------------------------------------------------
   // stimulus and observed signals
   // -----------------------------------------------------------------
   logic clk_sys;
   logic rst_n;
   logic [7:0] reg_addr;
   logic [7:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [7:0] reg_rdata;
   logic region_a_select;
   logic [MWSC_ADDR_W-1:0] cpu_addr;
   logic smi_active;
   logic win_a_hit;
   logic [2:0] win_a_index;
   logic [MWSC_WIN_A*MWSC_PAGE_W-1:0] window_region_a_page;
   logic win_b_hit;
   logic [1:0] win_b_index;
   logic [MWSC_WIN_B*MWSC_PAGE_W-1:0] window_region_b_page;
   logic [MWSC_ADDR_W-1:0] window_region_a_addr;
   logic window_region_a_valid;
   logic [MWSC_ADDR_W-1:0] window_region_b_addr;
   logic window_region_b_valid;
   logic [15:0] shadow_en;
   logic shadow_hit;
   logic idle_clk_low_sel;
   logic a20_out;
   int error_cnt;
   int checks;
   // values the bench programs, kept here so expectations never come from the design
   logic [7:0] hp = 8'he4;
   logic [7:0] b23a = 8'ha5;
   logic [3:0] b23b = 4'hc;
   logic [7:0] lp = 8'h9c;
   logic [15:0] sh = 16'ha55a;
   logic [7:0] idx_tab [6] = '{8'h67, 8'h68, 8'h69, 8'h6a, 8'h6b, 8'h6c};

   mwsc_config mwsc_config_i (
      .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .region_a_select(region_a_select), .cpu_addr(cpu_addr),
      .smi_active(smi_active), .win_a_hit(win_a_hit), .win_a_index(win_a_index),
      .window_region_a_page(window_region_a_page), .win_b_hit(win_b_hit), .win_b_index(win_b_index),
      .window_region_b_page(window_region_b_page), .window_region_a_addr(window_region_a_addr),
      .window_region_a_valid(window_region_a_valid), .window_region_b_addr(window_region_b_addr),
      .window_region_b_valid(window_region_b_valid), .shadow_en(shadow_en), .shadow_hit(shadow_hit),
      .idle_clk_low_sel(idle_clk_low_sel), .a20_out(a20_out)
   );

   // 250 MHz system clock
   always #2 clk_sys = ~clk_sys;

   // -----------------------------------------------------------------
   // access tasks: each starts on a rising edge and ends just after one
   // -----------------------------------------------------------------
   task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string msg);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
      end
   endtask

   task automatic stop_test;
      $display("mismatches %0d, comparisons %0d", error_cnt, checks);
      if (error_cnt == 0 && checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // one-cycle write strobe; the 1 ns wait after the closing edge keeps the strobe from being driven twice in one step
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      #1;
   endtask

   // read data stands only in the cycle after the strobe, so it is sampled there
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1;
      chk({16'h0000, reg_rdata}, {16'h0000, exp}, "register read");
   endtask

   // write then read back on the very next cycle, then see the read data drop
   task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] exp);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1;
      chk({16'h0000, reg_rdata}, {16'h0000, exp}, "read right after write");
      @(posedge clk_sys);
      #1;
      chk({16'h0000, reg_rdata}, 24'h0, "read data one cycle only");
   endtask

   task automatic sel(input logic s);
      @(posedge clk_sys);
      region_a_select <= s;
      #1;
   endtask

   // present a cpu address and smi level, both left in place when the task ends; registered outputs are looked at after the next edge
   task automatic smp(input logic [23:0] a, input logic smi);
      @(posedge clk_sys);
      cpu_addr <= a;
      smi_active <= smi;
      @(posedge clk_sys);
      #1;
   endtask

   function automatic logic [2:0] ext_of(input logic sel_b, input int idx);
      if (!sel_b && idx >= 4) begin
         return {b23a[idx], hp[2*(idx-4) +: 2]};
      end
      return {sel_b ? b23b[idx] : b23a[idx], lp[2*idx +: 2]};
   endfunction

   task automatic xlate(input logic sel_b, input int idx, input logic [23:0] a);
      logic [6:0] pg;
      pg = sel_b ? window_region_b_page[7*idx +: 7] : window_region_a_page[7*idx +: 7];
      @(posedge clk_sys);
      cpu_addr <= a;
      win_a_hit <= ~sel_b;
      win_b_hit <= sel_b;
      win_a_index <= idx[2:0];
      win_b_index <= idx[1:0];
      @(posedge clk_sys);
      win_a_hit <= 1'b0;
      win_b_hit <= 1'b0;
      #1;
      chk(sel_b ? window_region_b_addr : window_region_a_addr, {ext_of(sel_b, idx), pg, a[13:0]}, "address");
      chk({23'h0, sel_b ? window_region_b_valid : window_region_a_valid}, 24'h1, "valid high");
      @(posedge clk_sys);
      #1;
      chk({23'h0, sel_b ? window_region_b_valid : window_region_a_valid}, 24'h0, "valid one cycle");
   endtask

   // -----------------------------------------------------------------
   // main sequence
   // -----------------------------------------------------------------
   initial begin
      clk_sys = 1'b0;
      rst_n = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      region_a_select = 1'b1;
      cpu_addr = 24'h000000;
      smi_active = 1'b0;
      win_a_hit = 1'b0;
      win_a_index = 3'h0;
      win_b_hit = 1'b0;
      win_b_index = 2'h0;
      error_cnt = 0;
      checks = 0;
      for (int n = 0; n < 8; n++) begin
         window_region_a_page[7*n +: 7] = 7'h41 + 7'(n * 9);
      end
      for (int n = 0; n < 4; n++) begin
         window_region_b_page[7*n +: 7] = 7'h23 + 7'(n * 5);
      end
      repeat (6) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk_sys);
      // reset values of indexes 67h to 6ch; the low-page extension at 6eh is not read
      chk({8'h00, shadow_en}, 24'h0, "shadow enables after reset");
      foreach (idx_tab[i]) rd(idx_tab[i], 8'h00);
      // shadow enables, one block per bit, boundaries just outside the range
      wr(MWSC_IDX_SHADOW_LOW, sh[7:0]);
      wr(MWSC_IDX_SHADOW_HIGH, sh[15:8]);
      chk({8'h00, shadow_en}, {8'h00, sh}, "shadow enable outputs");
      rd(MWSC_IDX_SHADOW_LOW, sh[7:0]);
      rd(MWSC_IDX_SHADOW_HIGH, sh[15:8]);
      for (int k = 0; k < 16; k++) begin
         smp(24'h0c0000 + 24'(k * 24'h4000) + 24'h03ff, 1'b0);
         chk({23'h0, shadow_hit}, {23'h0, sh[k]}, "shadow block hit");
      end
      smp(24'h0bffff, 1'b0);
      chk({23'h0, shadow_hit}, 24'h0, "below shadow range");
      smp(24'h100000, 1'b0);
      chk({23'h0, shadow_hit}, 24'h0, "above shadow range");
      // reserved and unmapped indexes keep reading zero
      wr(MWSC_IDX_RESERVED, 8'hff);
      rd(MWSC_IDX_RESERVED, 8'h00);
      wr(8'h70, 8'hff);
      rd(8'h70, 8'h00);
      // misc control two: only idle, a20 pass and bit 4 are stored
      wr(MWSC_IDX_MISC_TWO, 8'hff);
      rd(MWSC_IDX_MISC_TWO, 8'h15);
      chk({23'h0, idle_clk_low_sel}, 24'h1, "idle on slow clock");
      smp(24'h100000, 1'b1);
      chk({23'h0, a20_out}, 24'h1, "a20 passes in smi");
      wr(MWSC_IDX_MISC_TWO, 8'h10);
      chk({23'h0, idle_clk_low_sel}, 24'h0, "idle on fast clock");
      smp(24'h100000, 1'b1);
      chk({23'h0, a20_out}, 24'h0, "a20 forced low in smi");
      smp(24'h100000, 1'b0);
      chk({23'h0, a20_out}, 24'h1, "a20 outside smi");
      smp(24'h0fffff, 1'b0);
      chk({23'h0, a20_out}, 24'h0, "a20 low address");
      // high-page extension needs region a selected
      sel(1'b0);
      wr(MWSC_IDX_HIGH_PAGE_EXT, 8'hff);
      sel(1'b1);
      rd(MWSC_IDX_HIGH_PAGE_EXT, 8'h00);
      wr(MWSC_IDX_HIGH_PAGE_EXT, hp);
      rd(MWSC_IDX_HIGH_PAGE_EXT, hp);
      // bit-23 register: low nibble held once per region
      wr_rd(MWSC_IDX_BIT23_EXT, 8'h5a, 8'h5a);
      wr(MWSC_IDX_BIT23_EXT, b23a);
      rd(MWSC_IDX_BIT23_EXT, b23a);
      sel(1'b0);
      wr(MWSC_IDX_BIT23_EXT, {4'hf, b23b});
      rd(MWSC_IDX_BIT23_EXT, {4'h0, b23b});
      sel(1'b1);
      rd(MWSC_IDX_BIT23_EXT, b23a);
      wr(MWSC_IDX_LOW_PAGE_EXT, lp);
      // translations across both regions and both extension registers
      xlate(1'b0, 7, 24'h0d6abc);
      xlate(1'b0, 4, 24'h0c1234);
      xlate(1'b0, 5, 24'h0d6abc);
      xlate(1'b0, 2, 24'h0c3fff);
      xlate(1'b1, 2, 24'h0a5555);
      sel(1'b0);
      xlate(1'b1, 1, 24'h0a0001);
      // a second reset in mid-run clears the shadow map at once
      @(posedge clk_sys);
      rst_n <= 1'b0;
      @(posedge clk_sys);
      #1;
      chk({8'h00, shadow_en}, 24'h0, "shadow enables after second reset");
      @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk_sys);
      stop_test();
   end

   // watchdog so a stuck sequence still reaches the verdict
   initial begin
      repeat (5000) @(posedge clk_sys);
      error_cnt++;
      $display("wrong value at %0t: run did not finish in time", $time);
      stop_test();
   end
endmodule
